//--- hw/cmpb_defs.vh
/*
  Register map, field positions and reset values for the second
  comparator control block. Included by the design files.
*/
`ifndef CMPB_DEFS_VH
`define CMPB_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CMPB_CTRL_ADDR 4'h0
`define CMPB_SHARED_ADDR 4'h4
`define CMPB_PORT_ADDR 4'h8
`define CMPB_ANSEL_ADDR 4'hC

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CMPB_ENABLE_BIT 7
`define CMPB_RESULT_BIT 6
`define CMPB_PIN_DRIVE_BIT 5
`define CMPB_INVERT_BIT 4
`define CMPB_REF_SEL_BIT 2
`define CMPB_CH_HI_BIT 1
`define CMPB_CH_LO_BIT 0
`define CMPB_CTRL_WMASK 8'hB7
`define CMPB_CTRL_RESET 8'h00

// ----------------------------------------------------------------
// Shared control register fields
// ----------------------------------------------------------------
`define CMPB_MIRROR_A_BIT 7
`define CMPB_MIRROR_B_BIT 6
`define CMPB_SYNC_BIT 0
`define CMPB_SHARED_WMASK 8'h1F
`define CMPB_SHARED_RESET 8'h02

// ----------------------------------------------------------------
// Analog select reset and bus response codes
// ----------------------------------------------------------------
`define CMPB_ANSEL_RESET 8'hFF
`define CMPB_RESP_OKAY 2'b00
`define CMPB_RESP_SLVERR 2'b10

`endif

//--- hw/cmpb_sync.v
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous input and the aclk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module cmpb_sync (
  input wire aclk,
  input wire aresetn,
  input wire async_in,
  output reg sync_out
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // ----------------------------------------------------------------
  // Sync chain
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sync_out <= s3_q;
      end
    end
  end

endmodule // cmpb_sync

`default_nettype wire

//--- hw/cmpb_top.v
/*
  Second comparator control logic with AXI4-Lite register slave.
  Assumes analog comparator results arrive as asynchronous levels
  and that the timer clock arrives as an asynchronous level.
*/
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cmpb_defs.vh"

module cmpb_top #(
  parameter PORT_W = 8,
  parameter PIN_IDX = 0
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cmp_b_raw,
  input wire cmp_a_result,
  input wire timer_clk,
  input wire [PORT_W-1:0] port_pins,
  input wire [PORT_W-1:0] pin_direction_bit,
  output reg cmp_b_pin_out,
  output reg cmp_b_pin_oe_n,
  output reg [1:0] cmp_b_channel_select,
  output reg cmp_b_reference_select,
  output reg cmp_b_active,
  output reg cmp_b_changed
);

  reg [7:0] ctrl_q;
  reg [7:0] shared_q;
  reg [PORT_W-1:0] ansel_q;
  reg cmp_b_result_q;
  reg cmp_b_mismatch_q;
  reg tclk_prev_q;
  reg aw_q;
  reg [3:0] aw_addr_q;
  reg w_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire raw_s;
  wire cmpa_s;
  wire tclk_s;
  wire [PORT_W-1:0] pins_s;
  wire cmp_b_enable;
  wire cmp_b_invert;
  wire cmp_b_sync;
  wire cmp_b_comb;
  wire tclk_fall;
  wire do_write;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  cmpb_sync u_raw (.aclk(aclk), .aresetn(aresetn), .async_in(cmp_b_raw),
    .sync_out(raw_s));
  cmpb_sync u_cmpa (.aclk(aclk), .aresetn(aresetn),
    .async_in(cmp_a_result), .sync_out(cmpa_s));
  cmpb_sync u_tclk (.aclk(aclk), .aresetn(aresetn), .async_in(timer_clk),
    .sync_out(tclk_s));

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_pin
      cmpb_sync u_pin (.aclk(aclk), .aresetn(aresetn),
        .async_in(port_pins[gi]), .sync_out(pins_s[gi]));
    end
  endgenerate

  assign cmp_b_enable = ctrl_q[`CMPB_ENABLE_BIT];
  assign cmp_b_invert = ctrl_q[`CMPB_INVERT_BIT];
  assign cmp_b_sync = shared_q[`CMPB_SYNC_BIT];
  assign cmp_b_comb = cmp_b_enable & (raw_s ^ cmp_b_invert);
  assign tclk_fall = tclk_prev_q & ~tclk_s;

  // ----------------------------------------------------------------
  // Comparator result
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmp_b_result_q <= 1'b0;
      tclk_prev_q <= 1'b0;
      cmp_b_mismatch_q <= 1'b0;
      cmp_b_changed <= 1'b0;
    end else begin
      tclk_prev_q <= tclk_s;
      if (!cmp_b_enable) begin
        cmp_b_result_q <= 1'b0;
      end else if (!cmp_b_sync || tclk_fall) begin
        cmp_b_result_q <= cmp_b_comb;
      end
      // Mismatch latch, no read side effect
      cmp_b_mismatch_q <= cmp_b_result_q;
      cmp_b_changed <= cmp_b_mismatch_q ^ cmp_b_result_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin and analog controls
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmp_b_pin_out <= 1'b0;
      cmp_b_pin_oe_n <= 1'b1;
      cmp_b_channel_select <= 2'b00;
      cmp_b_reference_select <= 1'b0;
      cmp_b_active <= 1'b0;
    end else begin
      cmp_b_pin_out <= cmp_b_result_q;
      cmp_b_pin_oe_n <= ~(ctrl_q[`CMPB_PIN_DRIVE_BIT] & cmp_b_enable &
        ~pin_direction_bit[PIN_IDX]);
      cmp_b_channel_select <= ctrl_q[`CMPB_CH_HI_BIT:`CMPB_CH_LO_BIT];
      cmp_b_reference_select <= ctrl_q[`CMPB_REF_SEL_BIT];
      cmp_b_active <= cmp_b_enable;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_q & ~s_axi_bvalid;
  assign do_write = aw_q & w_q & ~s_axi_bvalid;

  function [7:0] merge8;
    input [7:0] old;
    input [7:0] data;
    input [7:0] wmask;
    input en;
    begin
      merge8 = en ? ((old & ~wmask) | (data & wmask)) : old;
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMPB_RESP_OKAY;
      ctrl_q <= `CMPB_CTRL_RESET;
      shared_q <= `CMPB_SHARED_RESET;
      ansel_q <= {PORT_W{1'b1}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CMPB_RESP_OKAY;
        case (aw_addr_q)
          `CMPB_CTRL_ADDR: begin
            ctrl_q <= merge8(ctrl_q, w_data_q[7:0], `CMPB_CTRL_WMASK,
              w_strb_q[0]);
          end
          `CMPB_SHARED_ADDR: begin
            shared_q <= merge8(shared_q, w_data_q[7:0],
              `CMPB_SHARED_WMASK, w_strb_q[0]);
          end
          `CMPB_ANSEL_ADDR: begin
            if (w_strb_q[0]) begin
              ansel_q <= w_data_q[PORT_W-1:0];
            end
          end
          `CMPB_PORT_ADDR: begin
            s_axi_bresp <= `CMPB_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `CMPB_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CMPB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CMPB_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      case (s_axi_araddr)
        `CMPB_CTRL_ADDR: begin
          s_axi_rdata[7:0] <= (ctrl_q & `CMPB_CTRL_WMASK) |
            {1'b0, cmp_b_result_q, 6'h00};
        end
        `CMPB_SHARED_ADDR: begin
          s_axi_rdata[7:0] <= (shared_q & `CMPB_SHARED_WMASK) |
            {cmpa_s, cmp_b_result_q, 6'h00};
        end
        `CMPB_PORT_ADDR: begin
          s_axi_rdata[PORT_W-1:0] <= pins_s & ~ansel_q;
        end
        `CMPB_ANSEL_ADDR: begin
          s_axi_rdata[PORT_W-1:0] <= ansel_q;
        end
        default: begin
          s_axi_rresp <= `CMPB_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // cmpb_top

`default_nettype wire

//--- tb/cmpb_monitor.sv
/*
  Port checker for cmpb_top: bus handshakes and pin gating.
  Assumes binding into cmpb_top with its own parameters.
*/
`timescale 1ns/1ps
`default_nettype none

module cmpb_monitor #(
  parameter PORT_W = 8,
  parameter PIN_IDX = 0
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [PORT_W-1:0] pin_direction_bit,
  input wire cmp_b_pin_out,
  input wire cmp_b_pin_oe_n,
  input wire cmp_b_active,
  input wire cmp_b_changed
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_off; !cmp_b_active ##1 !cmp_b_active |-> !cmp_b_pin_out;
  endproperty
  a_off: assert property (p_off)
    else $error("result high while comparator off");
  property p_oe_on; !cmp_b_pin_oe_n |-> cmp_b_active; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("pin driven while comparator off");
  property p_oe_dir; $past(pin_direction_bit[PIN_IDX]) |-> cmp_b_pin_oe_n;
  endproperty
  a_oe_dir: assert property (p_oe_dir)
    else $error("pin driven while direction is input");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp); endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read response dropped early");
  property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_next: assert property (p_r_next)
    else $error("read answer late");
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_r_upper: assert property (p_r_upper)
    else $error("upper read bits not zero");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write accepted while response pending");
  property p_changed; cmp_b_changed == $changed(cmp_b_pin_out); endproperty
  a_changed: assert property (p_changed)
    else $error("change pulse does not follow the result");
endmodule // cmpb_monitor

bind cmpb_top cmpb_monitor #(.PORT_W(PORT_W), .PIN_IDX(PIN_IDX)) u_mon (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .pin_direction_bit, .cmp_b_pin_out, .cmp_b_pin_oe_n, .cmp_b_active,
  .cmp_b_changed
);

`default_nettype wire

//--- tb/cmpb_top_tb_top.sv
/*
  Register-level bench for cmpb_top over AXI4-Lite.
  Assumes the design under hw/ and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmpb_defs.vh"

module cmpb_top_tb_top;
  logic aclk = 0, aresetn = 0, cmp_b_raw = 1, cmp_a_result = 0;
  logic timer_clk = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [7:0] port_pins = 8'hAA, pin_direction_bit = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cmp_b_pin_out, cmp_b_pin_oe_n, cmp_b_reference_select;
  logic cmp_b_active, cmp_b_changed;
  logic [1:0] s_axi_bresp, s_axi_rresp, cmp_b_channel_select;
  logic [31:0] s_axi_rdata;
  int n_mismatch = 0, checks = 0;
  int n_pulse = 0;

  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    if (cmp_b_changed === 1'b1) n_pulse <= n_pulse + 1;
  end

  cmpb_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmp_b_raw, .cmp_a_result, .timer_clk,
    .port_pins, .pin_direction_bit, .cmp_b_pin_out, .cmp_b_pin_oe_n,
    .cmp_b_channel_select, .cmp_b_reference_select, .cmp_b_active,
    .cmp_b_changed);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input [31:0] seen, input [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input [3:0] a, input [7:0] d, input [3:0] s, input [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk(s_axi_bresp, r);
    @(posedge aclk);
  endtask
  task rd(input [3:0] a, input [7:0] d, input [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk(s_axi_rdata, {24'h000000, d});
    chk(s_axi_rresp, r);
    @(posedge aclk);
  endtask
  task print_verdict;
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`CMPB_CTRL_ADDR, 8'h00, 2'h0);
    rd(`CMPB_SHARED_ADDR, 8'h02, 2'h0);
    rd(`CMPB_ANSEL_ADDR, 8'hFF, 2'h0);
    rd(`CMPB_PORT_ADDR, 8'h00, 2'h0);
    wr(`CMPB_ANSEL_ADDR, 8'hF0, 4'hF, 2'h0);
    wr(`CMPB_PORT_ADDR, 8'h55, 4'hF, 2'h0);
    wt(12);
    rd(`CMPB_PORT_ADDR, 8'h0A, 2'h0);
    wr(`CMPB_CTRL_ADDR, 8'h4C, 4'hF, 2'h0);
    rd(`CMPB_CTRL_ADDR, 8'h04, 2'h0);
    for (int c = 0; c < 4; c++) begin
      wr(`CMPB_CTRL_ADDR, 8'h80 | c[1:0] | {c[0], 2'h0}, 4'hF, 2'h0);
      wt(2);
      chk(cmp_b_channel_select, c[1:0]);
      chk(cmp_b_reference_select, c[0]);
      chk(cmp_b_active, 1'b1);
      chk(cmp_b_pin_oe_n, 1'b1);
    end
    cmp_a_result <= 1;
    wt(12);
    rd(`CMPB_CTRL_ADDR, 8'hC7, 2'h0);
    rd(`CMPB_SHARED_ADDR, 8'hC2, 2'h0);
    chk(cmp_b_changed, 1'b0);
    chk(n_pulse, 1);
    wr(`CMPB_CTRL_ADDR, 8'hB0, 4'hF, 2'h0);
    wt(12);
    rd(`CMPB_CTRL_ADDR, 8'hB0, 2'h0);
    chk(cmp_b_pin_oe_n, 1'b0);
    chk(cmp_b_pin_out, 1'b0);
    cmp_b_raw <= 0;
    wt(12);
    chk(cmp_b_pin_out, 1'b1);
    pin_direction_bit <= 8'h01;
    wt(3);
    chk(cmp_b_pin_oe_n, 1'b1);
    pin_direction_bit <= 8'h00;
    wr(`CMPB_CTRL_ADDR, 8'h20, 4'hF, 2'h0);
    wt(12);
    chk(cmp_b_pin_oe_n, 1'b1);
    chk(cmp_b_pin_out, 1'b0);
    wr(`CMPB_CTRL_ADDR, 8'h80, 4'h0, 2'h0);
    rd(`CMPB_CTRL_ADDR, 8'h20, 2'h0);
    wr(4'h2, 8'h80, 4'hF, `CMPB_RESP_SLVERR);
    rd(4'h2, 8'h00, `CMPB_RESP_SLVERR);
    wr(`CMPB_SHARED_ADDR, 8'h03, 4'hF, 2'h0);
    cmp_b_raw <= 1;
    wr(`CMPB_CTRL_ADDR, 8'h80, 4'hF, 2'h0);
    wt(12);
    rd(`CMPB_CTRL_ADDR, 8'h80, 2'h0);
    timer_clk <= 0;
    wt(12);
    rd(`CMPB_CTRL_ADDR, 8'hC0, 2'h0);
    rd(`CMPB_SHARED_ADDR, 8'hC3, 2'h0);
    cmp_b_raw <= 0;
    wt(12);
    rd(`CMPB_CTRL_ADDR, 8'hC0, 2'h0);
    timer_clk <= 1;
    wt(12);
    rd(`CMPB_CTRL_ADDR, 8'hC0, 2'h0);
    timer_clk <= 0;
    wt(12);
    rd(`CMPB_CTRL_ADDR, 8'h80, 2'h0);
    chk(n_pulse, 6);
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    print_verdict;
  end
endmodule // cmpb_top_tb_top

`default_nettype wire
